// >>> design/gcra_fifo.sv
// small synchronous fifo with registered read data and registered ready
`timescale 1ns/1ns
module gcra_fifo #(
	parameter int unsigned WIDTH = 10,
	parameter int unsigned DEPTH = 8
) (
	input  wire logic             clk_in,
	input  wire logic             rstn_in,
	input  wire logic             in_valid_in,
	input  wire logic [WIDTH-1:0] in_data_in,
	output logic                  in_ready_out,
	output logic                  out_valid_out,
	output logic [WIDTH-1:0]      out_data_out,
	input  wire logic             out_ready_in
);

	localparam int unsigned AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW-1:0]    wr_ptr_q;
	logic [AW-1:0]    rd_ptr_q;
	logic [AW:0]      cnt_q;
	logic [AW:0]      cnt_d;
	logic             in_ready_q;
	logic             out_valid_q;
	logic [WIDTH-1:0] out_data_q;
	logic             wr;
	logic             ld;

	assign wr            = in_valid_in && in_ready_q;
	assign ld            = (cnt_q != '0) && (!out_valid_q || out_ready_in);
	assign cnt_d         = cnt_q + {{AW{1'b0}}, wr} - {{AW{1'b0}}, ld};
	assign in_ready_out  = in_ready_q;
	assign out_valid_out = out_valid_q;
	assign out_data_out  = out_data_q;

	always_ff @(posedge clk_in) begin
		if (wr) begin
			mem_q[wr_ptr_q] <= in_data_in;
		end
	end

	// ready is a flop loaded from the next count, so it drops in the same cycle the fifo turns full
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			wr_ptr_q   <= '0;
			rd_ptr_q   <= '0;
			cnt_q      <= '0;
			in_ready_q <= 1'b0;
		end else begin
			wr_ptr_q   <= wr ? AW'(wr_ptr_q + 1'b1) : wr_ptr_q;
			rd_ptr_q   <= ld ? AW'(rd_ptr_q + 1'b1) : rd_ptr_q;
			cnt_q      <= cnt_d;
			in_ready_q <= cnt_d < (AW+1)'(DEPTH);
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			out_valid_q <= 1'b0;
			out_data_q  <= '0;
		end else if (ld) begin
			out_valid_q <= 1'b1;
			out_data_q  <= mem_q[rd_ptr_q];
		end else if (out_ready_in) begin
			out_valid_q <= 1'b0;
		end
	end

endmodule

// >>> design/gcra_pacer.sv
// clock enable source: one pulse per speed-dependent period
`timescale 1ns/1ns
module gcra_pacer
	import gcra_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire gcra_speed_t speed_in,
	output logic             ce_out
);

	logic [6:0]  cnt_q;
	logic [6:0]  per;
	gcra_speed_t spd_q;
	logic        ce_q;

	assign per    = gcra_period(speed_in);
	assign ce_out = ce_q;

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			spd_q <= GCRA_SPD_1000;
		end else begin
			spd_q <= speed_in;
		end
	end

	// restart on a speed change so the first pulse after it is already evenly spaced
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt_q <= 7'h00;
		end else if (spd_q != speed_in || cnt_q >= per - 7'h01) begin
			cnt_q <= 7'h00;
		end else begin
			cnt_q <= cnt_q + 7'h01;
		end
	end

	// single-cycle pulse when the count wraps; period 1 holds it high every cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ce_q <= 1'b0;
		end else if (per == GCRA_PER_1000) begin
			ce_q <= 1'b1;
		end else begin
			ce_q <= (spd_q != speed_in) || (cnt_q >= per - 7'h01);
		end
	end

endmodule

// >>> design/gcra_pkg.sv
// package: shared types and constants for the gmii clock enable rate adapter
package gcra_pkg;

	// line speed selection code
	typedef enum logic [1:0] {
		GCRA_SPD_10   = 2'b00,
		GCRA_SPD_100  = 2'b01,
		GCRA_SPD_1000 = 2'b10,
		GCRA_SPD_RSVD = 2'b11
	} gcra_speed_t;

	// one (g)mii beat: data byte plus its two control bits
	typedef struct packed {
		logic [7:0] data;
		logic       en;
		logic       er;
	} gcra_beat_t;

	localparam int unsigned GCRA_BEAT_W    = 10;
	localparam int unsigned GCRA_FIFO_DEPTH = 8;
	localparam int unsigned GCRA_CNT_W     = 7;

	// enable period in reference clock cycles per speed
	localparam logic [6:0] GCRA_PER_1000 = 7'h01;
	localparam logic [6:0] GCRA_PER_100  = 7'h0a;
	localparam logic [6:0] GCRA_PER_10   = 7'h64;

	localparam gcra_beat_t GCRA_BEAT_IDLE = '{data: 8'h00, en: 1'b0, er: 1'b0};

	// reserved code falls back to gigabit pacing
	function automatic logic [6:0] gcra_period(input gcra_speed_t spd);
		logic [6:0] per;
		per = GCRA_PER_1000;
		unique case (spd)
			GCRA_SPD_10:   per = GCRA_PER_10;
			GCRA_SPD_100:  per = GCRA_PER_100;
			GCRA_SPD_1000: per = GCRA_PER_1000;
			GCRA_SPD_RSVD: per = GCRA_PER_1000;
		endcase
		return per;
	endfunction

endpackage

// >>> design/gcra_top.sv
// top: (g)mii clock enable pacing, transmit capture with fifo, receive launch
// Function
// - transmit enable source comes from transmit pacing on the inbound reference clock.
// - 100 Mbps asserts the enable source one cycle in ten.
// - 10 Mbps asserts the enable source one cycle in one hundred.
// - transmit data and control are captured only when the transmit sink is high.
// - receive enable source follows the same speed pacing as transmit.
// - receive data and control change only when the receive sink is high.
// - receive outputs are timed from the single reference clock, no own clock.
// - transmit inputs are registered on the single reference clock, no own clock.
`timescale 1ns/1ns
module gcra_top
	import gcra_pkg::*;
(
	input  wire logic        clk_in,
	input  wire logic        rstn_in,
	input  wire logic [1:0]  speed_in,
	output logic             tx_ce_src_out,
	input  wire logic        tx_ce_sink_in,
	input  wire logic [7:0]  txd_in,
	input  wire logic        tx_en_in,
	input  wire logic        tx_er_in,
	output logic             tx_ready_out,
	output logic             tx_drop_out,
	output gcra_beat_t       tx_pcs_out,
	output logic             tx_pcs_valid_out,
	input  wire logic        tx_pcs_ready_in,
	output logic             rx_ce_src_out,
	input  wire logic        rx_ce_sink_in,
	input  wire gcra_beat_t  rx_pcs_in,
	input  wire logic        rx_pcs_valid_in,
	output logic             rx_pcs_ready_out,
	output logic [7:0]       rxd_out,
	output logic             rx_dv_out,
	output logic             rx_er_out
);

	logic [1:0]  spd_meta_q;
	logic [1:0]  spd_sync_q;
	gcra_speed_t spd;
	gcra_beat_t  tx_cap_q;
	logic        tx_cap_vld_q;
	logic        tx_drop_q;
	logic        fifo_in_ready;
	logic [9:0]  fifo_out_data;
	gcra_beat_t  rx_hold_q;
	logic        rx_hold_full_q;
	logic        rx_ready_q;
	gcra_beat_t  rx_gmii_q;
	logic        rx_accept;
	logic        rx_hold_full_d;

	// speed straps arrive asynchronously: two flops before use
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			spd_meta_q <= 2'h0;
			spd_sync_q <= 2'h0;
		end else begin
			spd_meta_q <= speed_in;
			spd_sync_q <= spd_meta_q;
		end
	end

	assign spd = gcra_speed_t'(spd_sync_q);

	// one pacer per direction; both run on the one reference clock
	gcra_pacer u_tx_pacer (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.speed_in (spd),
		.ce_out   (tx_ce_src_out)
	);

	gcra_pacer u_rx_pacer (
		.clk_in   (clk_in),
		.rstn_in  (rstn_in),
		.speed_in (spd),
		.ce_out   (rx_ce_src_out)
	);

	// transmit beats are sampled only on qualified edges of the reference clock
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_cap_q     <= GCRA_BEAT_IDLE;
			tx_cap_vld_q <= 1'b0;
		end else begin
			tx_cap_vld_q <= tx_ce_sink_in;
			if (tx_ce_sink_in) begin
				tx_cap_q <= '{data: txd_in, en: tx_en_in, er: tx_er_in};
			end
		end
	end

	// a beat that meets a full fifo is lost; flag it for one cycle
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			tx_drop_q <= 1'b0;
		end else begin
			tx_drop_q <= tx_cap_vld_q && !fifo_in_ready;
		end
	end

	assign tx_drop_out  = tx_drop_q;
	assign tx_ready_out = fifo_in_ready;

	gcra_fifo #(
		.WIDTH (GCRA_BEAT_W),
		.DEPTH (GCRA_FIFO_DEPTH)
	) u_tx_fifo (
		.clk_in        (clk_in),
		.rstn_in       (rstn_in),
		.in_valid_in   (tx_cap_vld_q),
		.in_data_in    (tx_cap_q),
		.in_ready_out  (fifo_in_ready),
		.out_valid_out (tx_pcs_valid_out),
		.out_data_out  (fifo_out_data),
		.out_ready_in  (tx_pcs_ready_in)
	);

	assign tx_pcs_out = gcra_beat_t'(fifo_out_data);

	// receive side: one-beat holding register ahead of the launch stage
	always_comb begin
		rx_accept      = rx_pcs_valid_in && rx_ready_q;
		rx_hold_full_d = rx_hold_full_q;
		if (rx_ce_sink_in) begin
			rx_hold_full_d = 1'b0;
		end
		if (rx_accept) begin
			rx_hold_full_d = 1'b1;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_hold_q <= GCRA_BEAT_IDLE;
		end else if (rx_accept) begin
			rx_hold_q <= rx_pcs_in;
		end
	end

	// ready is registered; it drops as soon as the holding register fills
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_hold_full_q <= 1'b0;
			rx_ready_q     <= 1'b0;
		end else begin
			rx_hold_full_q <= rx_hold_full_d;
			rx_ready_q     <= !rx_hold_full_d;
		end
	end

	assign rx_pcs_ready_out = rx_ready_q;

	// launch only on qualified edges; an empty holder launches an idle beat
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rx_gmii_q <= GCRA_BEAT_IDLE;
		end else if (rx_ce_sink_in) begin
			rx_gmii_q <= rx_hold_full_q ? rx_hold_q : GCRA_BEAT_IDLE;
		end
	end

	assign rxd_out   = rx_gmii_q.data;
	assign rx_dv_out = rx_gmii_q.en;
	assign rx_er_out = rx_gmii_q.er;

endmodule

// >>> tb/gcra_mac_model.sv
// partner: mac transmit side, launches beats on the clock enable
`timescale 1ns/1ns
module gcra_mac_model
	import gcra_pkg::*;
(
	input  wire logic       clk_in,
	input  wire logic       rstn_in,
	input  wire logic       ce_in,
	input  wire gcra_beat_t nxt_in,
	output gcra_beat_t      beat_out
);
	// a beat changes only after a qualified edge, so each one is seen whole
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in)
			beat_out <= GCRA_BEAT_IDLE;
		else if (ce_in)
			beat_out <= nxt_in;
	end
endmodule

// >>> tb/gcra_properties.sv
// checker: pacing and handshake properties of the rate adapter top
`timescale 1ns/1ns
module gcra_properties
	import gcra_pkg::*;
(
	input wire logic       clk_in,
	input wire logic       rstn_in,
	input wire logic [1:0] speed_in,
	input wire logic       tx_ce_src_out,
	input wire logic       tx_ce_sink_in,
	input wire logic       tx_pcs_valid_out,
	input wire logic       tx_pcs_ready_in,
	input wire gcra_beat_t tx_pcs_out,
	input wire logic       rx_ce_src_out,
	input wire logic       rx_ce_sink_in,
	input wire logic [7:0] rxd_out,
	input wire logic       rx_dv_out,
	input wire logic       rx_er_out,
	input wire logic       rx_pcs_valid_in,
	input wire logic       rx_pcs_ready_out
);
	logic [6:0] gap_q;
	logic [1:0] nce_q;
	// the first pulses after reset may restart on speed sync, so only judge from the fourth on
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			gap_q <= 7'h00;
			nce_q <= 2'h0;
		end else if (tx_ce_src_out) begin
			gap_q <= 7'h00;
			nce_q <= nce_q + {1'b0, nce_q != 2'h3};
		end else begin
			gap_q <= gap_q + 7'h01;
		end
	end
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rstn_in);
	a_gap_exact: assert property (tx_ce_src_out && nce_q == 2'h3 |->
		gap_q == (speed_in == 2'h0 ? 7'h63 : speed_in == 2'h1 ? 7'h09 : 7'h00))
		else $error("enable spacing wrong");
	a_gig_high: assert property (speed_in[1] [*6] |-> tx_ce_src_out)
		else $error("gigabit enable low");
	a_pulse_narrow: assert property (tx_ce_src_out && !speed_in[1] && nce_q == 2'h3 |=>
		!tx_ce_src_out) else $error("enable pulse too wide");
	a_same_pace: assert property (rx_ce_src_out == tx_ce_src_out)
		else $error("receive pacing differs");
	a_rx_hold: assert property (!rx_ce_sink_in |=> $stable({rxd_out, rx_dv_out, rx_er_out}))
		else $error("receive output moved unqualified");
	a_head_hold: assert property (tx_pcs_valid_out && !tx_pcs_ready_in |=>
		tx_pcs_valid_out && $stable(tx_pcs_out)) else $error("fifo head lost");
	a_capture_cause: assert property ($rose(tx_pcs_valid_out) |->
		$past(tx_ce_sink_in, 2) || $past(tx_ce_sink_in, 3)) else $error("beat without capture");
	a_rx_ready_drop: assert property (rx_pcs_valid_in && rx_pcs_ready_out |=> !rx_pcs_ready_out)
		else $error("receive ready stayed high");
	c_pop: cover property (tx_pcs_valid_out && tx_pcs_ready_in);
	c_slow: cover property (tx_ce_src_out && gap_q == 7'h63);
	c_launch: cover property (rx_dv_out && rx_ce_sink_in);
endmodule
bind gcra_top gcra_properties u_chk (
	.clk_in           (clk_in),
	.rstn_in          (rstn_in),
	.speed_in         (speed_in),
	.tx_ce_src_out    (tx_ce_src_out),
	.tx_ce_sink_in    (tx_ce_sink_in),
	.tx_pcs_valid_out (tx_pcs_valid_out),
	.tx_pcs_ready_in  (tx_pcs_ready_in),
	.tx_pcs_out       (tx_pcs_out),
	.rx_ce_src_out    (rx_ce_src_out),
	.rx_ce_sink_in    (rx_ce_sink_in),
	.rxd_out          (rxd_out),
	.rx_dv_out        (rx_dv_out),
	.rx_er_out        (rx_er_out),
	.rx_pcs_valid_in  (rx_pcs_valid_in),
	.rx_pcs_ready_out (rx_pcs_ready_out)
);

// >>> tb/gcra_top_tb_top.sv
// testbench: rate adapter top with mac model and queued expectations
`timescale 1ns/1ns
module gcra_top_tb_top;
	import gcra_pkg::*;
	logic       clk_in = 1'b0, rstn_in = 1'b0, chk = 1'b0, stall = 1'b0, tx_take = 1'b0;
	logic       rx_v = 1'b0, rce_q = 1'b0, tx_ce, rx_ce, tx_ready, tx_drop, tx_v, rx_rdy;
	logic       rx_dv, rx_er;
	logic [1:0] speed = 2'h0;
	logic [7:0] rxd;
	logic [31:0] seed = 32'h0000_dfa7;
	gcra_beat_t nxt = GCRA_BEAT_IDLE, rx_pcs = GCRA_BEAT_IDLE, mac, tx_pcs, tq[$], rq[$];
	int         miscompares = 0, n_checks = 0, n, k;
	gcra_mac_model u_mac (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(tx_ce), .nxt_in(nxt),
		.beat_out(mac));
	gcra_top u_dut (.clk_in(clk_in), .rstn_in(rstn_in), .speed_in(speed), .tx_ce_src_out(tx_ce),
		.tx_ce_sink_in(tx_ce), .txd_in(mac.data), .tx_en_in(mac.en), .tx_er_in(mac.er),
		.tx_ready_out(tx_ready), .tx_drop_out(tx_drop), .tx_pcs_out(tx_pcs),
		.tx_pcs_valid_out(tx_v), .tx_pcs_ready_in(tx_take), .rx_ce_src_out(rx_ce),
		.rx_ce_sink_in(rx_ce), .rx_pcs_in(rx_pcs), .rx_pcs_valid_in(rx_v),
		.rx_pcs_ready_out(rx_rdy), .rxd_out(rxd), .rx_dv_out(rx_dv), .rx_er_out(rx_er));
	initial forever #5 clk_in = ~clk_in;
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic check(input logic [9:0] got, input logic [9:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("ERROR %0t saw %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic do_reset(input logic [1:0] s);
		#1 rstn_in = 1'b0;
		speed = s;
		chk = 1'b0;
		repeat (6) @(posedge clk_in);
		#1 rstn_in = 1'b1;
		tq.delete();
		rq.delete();
	endtask
	// holds the offer until ready is seen high at an edge, then notes the beat
	task automatic rx_send(input gcra_beat_t b);
		rx_pcs = b;
		rx_v = 1'b1;
		k = 0;
		do begin
			@(posedge clk_in);
			k++;
		end while (rx_rdy !== 1'b1 && k < 400);
		if (rx_rdy !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
		rq.push_back(b);
		#1 rx_v = 1'b0;
		// let an edge pass so the next offer starts off the sampling edge
		@(posedge clk_in);
		#1;
	endtask
	always @(posedge clk_in) begin
		#1 nxt = 10'(rnd());
		tx_take = !stall && 1'(rnd());
	end
	always @(posedge clk_in) begin
		if (chk && tx_ce)
			tq.push_back(mac);
		if (chk && tx_v && tx_take)
			check(tx_pcs, tq.pop_front());
		if (chk && rx_dv && rce_q)
			check({rxd, rx_dv, rx_er}, rq.pop_front());
		rce_q = rx_ce;
	end
	initial begin
		do_reset(2'h0);
		n = 0;
		k = 0;
		repeat (400) begin
			@(posedge clk_in);
			n += tx_ce;
			k += rx_ce;
		end
		check(n, 4);
		check(k, 4);
		// gigabit and reserved codes pace as gigabit; stalled consumer fills the fifo
		stall = 1'b1;
		for (int s = 2; s < 4; s++) begin
			do_reset(2'(s));
			// speed straps need two edges to sync, then one more to reach the pacer
			repeat (4) @(posedge clk_in);
			n = 0;
			k = 0;
			repeat (30) begin
				@(posedge clk_in);
				n += tx_ce;
				k += tx_drop;
			end
			check(n, 30);
			check(tx_ready, 1'b0);
			check(k > 0, 1'b1);
		end
		stall = 1'b0;
		do_reset(2'h1);
		chk = 1'b1;
		repeat (40) rx_send('{data: seed[7:0], en: 1'b1, er: seed[9]});
		repeat (30) @(posedge clk_in);
		check(rq.size(), 0);
		check(tq.size() < 3, 1'b1);
		check(rx_dv, 1'b0);
		end_of_test();
	end
endmodule
